// ### include/rfsw_pkg.sv
// package: constants and carriers for the receive frame status words
package rfsw_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_MAXSZ  = 8'h04;
    localparam logic [7:0] OFS_WORD_A = 8'h08;
    localparam logic [7:0] OFS_WORD_B = 8'h0C;
    localparam logic [7:0] OFS_WORD_C = 8'h10;
    localparam logic [7:0] OFS_COUNT  = 8'h14;

    // control register fields
    localparam int CTL_KEEP_ERR   = 0;
    localparam int CTL_FCS_STRIP  = 1;
    localparam int CTL_STORE_WAKE = 2;
    localparam int CTL_ALWAYS_FWD = 3;
    localparam int CTL_DEEP_SUSP  = 4;
    localparam int CTL_SLOW_MODE  = 5;
    localparam int CTL_WIDTH      = 6;
    localparam logic [5:0]  CTRL_RESET  = 6'h20;
    localparam logic [13:0] MAXSZ_RESET = 14'h05EE;

    // first word fields
    localparam int A_IPV4_RAW_L3_SUM = 31;
    localparam int A_L4_RAW_L3_SUM   = 30;
    localparam int A_PROTO_LO  = 27;
    localparam int A_BCAST     = 25;
    localparam int A_GROUP     = 24;
    localparam int A_TAGGED    = 23;
    localparam int A_ANY_ERR   = 22;
    localparam int A_OVERSIZE  = 21;
    localparam int A_RUNT      = 20;
    localparam int A_LONG      = 19;
    localparam int A_PHY_ERR   = 18;
    localparam int A_MISALIGN  = 17;
    localparam int A_FCS       = 16;
    localparam int A_SINGLE    = 15;
    localparam int A_NO_RAW_L3_SUM   = 14;
    // third word fields
    localparam int C_WAKE      = 15;
    localparam int C_FILT_FAIL = 14;

    localparam logic [13:0] RUNT_BYTES = 14'h0040;
    localparam logic [13:0] FCS_BYTES  = 14'h0004;

    typedef enum logic [1:0] {
        RFSW_NON_IP = 2'b00,
        RFSW_TCP_IP = 2'b01,
        RFSW_UDP_IP = 2'b10,
        RFSW_OTH_IP = 2'b11
    } rfsw_proto_t;

    typedef struct packed {
        logic [47:0] dest_addr;   // first byte in [47:40]
        logic [13:0] byte_count;
        logic        fcs_bad;
        logic        misaligned;
        logic        wdt_cut;
        logic        short_frame;
        logic        ipv4_hdr_bad;
        logic        l4_bad;
        logic        no_l4_sum;
        rfsw_proto_t proto_class;
        logic        tag_removed;
        logic [15:0] tag;
        logic [15:0] raw_sum;
        logic        wake_hit;
        logic        filter_miss;
        logic        overflow;
    } rfsw_frame_t;

    typedef struct packed {
        logic [31:0] word_a;
        logic [31:0] word_b;
        logic [31:0] word_c;
    } rfsw_words_t;

    // reported length, four bytes less when the check sequence is stripped and the count is at least four
    function automatic logic [13:0] rfsw_fit_len(input logic [13:0] n, input logic strip);
        if (strip && n >= FCS_BYTES) begin
            return n - FCS_BYTES;
        end
        return n;
    endfunction : rfsw_fit_len

endpackage : rfsw_pkg

// ### src/rfsw_addr_class.sv
// destination address class decode
`timescale 1ns/10ps
module rfsw_addr_class (
    input  wire logic [47:0] dest_addr,
    output logic             all_stations_address_flag,
    output logic             group_address_flag,
    output logic             single_station_address_flag
);
    logic group_bit;

    // group bit is the lowest bit of the first address byte
    assign group_bit = dest_addr[40];
    assign all_stations_address_flag = &dest_addr;
    assign group_address_flag = group_bit & ~all_stations_address_flag;
    assign single_station_address_flag = ~group_bit;
endmodule : rfsw_addr_class

// ### src/rfsw_top.sv
// receive frame status word generator with wishbone control
`timescale 1ns/10ps
module rfsw_top (
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    // frame side
    input  wire logic                 rx_active,
    input  wire logic                 phy_rx_err,
    input  wire logic                 frame_done,
    input  wire rfsw_pkg::rfsw_frame_t frame_info,
    output rfsw_pkg::rfsw_words_t     status_words_q,
    output logic                      status_valid_q,
    output logic                      status_drop_q,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o
);
    logic [5:0]  ctrl_q;
    logic [13:0] max_size_q;
    logic        phy_err_q;
    logic [15:0] stored_cnt_q;
    logic [15:0] dropped_cnt_q;
    logic        wb_ack_q;
    logic [31:0] wb_dat_q;

    logic        bcast;
    logic        group;
    logic        single;
    logic        phy_error_flag;
    logic        runt;
    logic        too_long;
    logic        octet_misalign_flag;
    logic        fcs_flag;
    logic        any_error_summary;
    logic        wake_flag;
    logic        filter_reject_flag;
    logic        drop;
    logic [13:0] len_rep;
    rfsw_pkg::rfsw_words_t words_d;
    logic        wb_req;
    logic        wb_wr;

    rfsw_addr_class u_addr_class (
        .dest_addr                   (frame_info.dest_addr),
        .all_stations_address_flag   (bcast),
        .group_address_flag          (group),
        .single_station_address_flag (single)
    );

    // phy error seen anywhere in the frame
    assign phy_error_flag = phy_err_q | (rx_active & phy_rx_err);

    // phy error sticky across reception, restarted at frame end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            phy_err_q <= 1'b0;
        end else if (frame_done) begin
            phy_err_q <= 1'b0;
        end else if (rx_active && phy_rx_err) begin
            phy_err_q <= 1'b1;
        end
    end

    // short frame or below collision window
    assign runt = frame_info.short_frame || (frame_info.byte_count < rfsw_pkg::RUNT_BYTES);
    assign too_long = frame_info.byte_count > max_size_q;
    // partial octet with bad check, slow modes
    assign octet_misalign_flag = frame_info.misaligned & frame_info.fcs_bad
                               & ctrl_q[rfsw_pkg::CTL_SLOW_MODE];
    assign fcs_flag = frame_info.fcs_bad | phy_error_flag;
    assign any_error_summary = fcs_flag | octet_misalign_flag | phy_error_flag | too_long
                             | runt | frame_info.wdt_cut | frame_info.ipv4_hdr_bad
                             | frame_info.l4_bad;
    // wake flag only when stored in deepest suspend
    assign wake_flag = frame_info.wake_hit & ctrl_q[rfsw_pkg::CTL_DEEP_SUSP]
                     & ctrl_q[rfsw_pkg::CTL_STORE_WAKE];
    // filter fail needs the wake flag
    assign filter_reject_flag = wake_flag & frame_info.filter_miss
                              & ctrl_q[rfsw_pkg::CTL_ALWAYS_FWD];
    assign drop = frame_info.overflow | (runt & ~ctrl_q[rfsw_pkg::CTL_KEEP_ERR]);
    assign len_rep = rfsw_pkg::rfsw_fit_len(frame_info.byte_count,
                                            ctrl_q[rfsw_pkg::CTL_FCS_STRIP]);

    always_comb begin
        words_d = '0;
        words_d.word_a[rfsw_pkg::A_IPV4_RAW_L3_SUM] = frame_info.ipv4_hdr_bad;
        words_d.word_a[rfsw_pkg::A_L4_RAW_L3_SUM]   = frame_info.l4_bad;
        words_d.word_a[rfsw_pkg::A_PROTO_LO +: 2] = frame_info.proto_class;
        words_d.word_a[rfsw_pkg::A_BCAST]    = bcast;
        words_d.word_a[rfsw_pkg::A_GROUP]    = group;
        words_d.word_a[rfsw_pkg::A_TAGGED]   = frame_info.tag_removed;
        words_d.word_a[rfsw_pkg::A_ANY_ERR]  = any_error_summary;
        words_d.word_a[rfsw_pkg::A_OVERSIZE] = frame_info.wdt_cut;
        words_d.word_a[rfsw_pkg::A_RUNT]     = runt;
        words_d.word_a[rfsw_pkg::A_LONG]     = too_long;
        words_d.word_a[rfsw_pkg::A_PHY_ERR]  = phy_error_flag;
        words_d.word_a[rfsw_pkg::A_MISALIGN] = octet_misalign_flag;
        words_d.word_a[rfsw_pkg::A_FCS]      = fcs_flag;
        words_d.word_a[rfsw_pkg::A_SINGLE]   = single;
        words_d.word_a[rfsw_pkg::A_NO_RAW_L3_SUM]  = frame_info.no_l4_sum;
        words_d.word_a[13:0]                 = len_rep;
        words_d.word_b[31:16] = frame_info.raw_sum;
        // tag copied whole, undefined when untagged
        words_d.word_b[15:0]  = frame_info.tag;
        words_d.word_c[rfsw_pkg::C_WAKE]      = wake_flag;
        words_d.word_c[rfsw_pkg::C_FILT_FAIL] = filter_reject_flag;
        words_d.word_c[13:0] = 14'h0000;
    end

    // words held until the next frame so software can read them back
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            status_words_q <= '0;
            status_valid_q <= 1'b0;
            status_drop_q  <= 1'b0;
        end else begin
            status_valid_q <= frame_done;
            if (frame_done) begin
                status_words_q <= words_d;
                status_drop_q  <= drop;
            end
        end
    end

    // counters wrap; software takes differences
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stored_cnt_q  <= 16'h0000;
            dropped_cnt_q <= 16'h0000;
        end else if (frame_done) begin
            if (drop) begin
                dropped_cnt_q <= dropped_cnt_q + 16'h0001;
            end else begin
                stored_cnt_q <= stored_cnt_q + 16'h0001;
            end
        end
    end

    // wishbone: ack one cycle after the strobe, held off the cycle after
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_q;
    assign wb_wr  = wb_req & wb_we_i;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q     <= rfsw_pkg::CTRL_RESET;
            max_size_q <= rfsw_pkg::MAXSZ_RESET;
        end else if (wb_wr) begin
            if (wb_adr_i == rfsw_pkg::OFS_CTRL && wb_sel_i[0]) begin
                ctrl_q <= wb_dat_i[5:0];
            end
            if (wb_adr_i == rfsw_pkg::OFS_MAXSZ) begin
                if (wb_sel_i[0]) begin
                    max_size_q[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    max_size_q[13:8] <= wb_dat_i[13:8];
                end
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 32'h0000_0000;
        end else begin
            wb_ack_q <= wb_req;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    rfsw_pkg::OFS_CTRL:   wb_dat_q <= {26'h0000000, ctrl_q};
                    rfsw_pkg::OFS_MAXSZ:  wb_dat_q <= {18'h00000, max_size_q};
                    rfsw_pkg::OFS_WORD_A: wb_dat_q <= status_words_q.word_a;
                    rfsw_pkg::OFS_WORD_B: wb_dat_q <= status_words_q.word_b;
                    rfsw_pkg::OFS_WORD_C: wb_dat_q <= status_words_q.word_c;
                    rfsw_pkg::OFS_COUNT:  wb_dat_q <= {dropped_cnt_q, stored_cnt_q};
                    default:              wb_dat_q <= 32'h0000_0000;
                endcase
            end else begin
                wb_dat_q <= 32'h0000_0000;
            end
        end
    end

    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = wb_dat_q;

    // ---- checks ----
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_group_no_bcast: assert property (
        status_valid_q |-> !(status_words_q.word_a[rfsw_pkg::A_GROUP]
                             && status_words_q.word_a[rfsw_pkg::A_BCAST]))
        else $error("group flag set on broadcast");

    a_tag_copied: assert property (
        frame_done && frame_info.tag_removed |=> status_words_q.word_a[rfsw_pkg::A_TAGGED]
            && status_words_q.word_b[15:0] == $past(frame_info.tag))
        else $error("removed tag not reported");

    a_err_summary: assert property (
        status_valid_q |-> status_words_q.word_a[rfsw_pkg::A_ANY_ERR]
            == (|status_words_q.word_a[21:16] | |status_words_q.word_a[31:30]))
        else $error("summary error mismatch");

    a_runt_short: assert property (
        frame_done && frame_info.byte_count < 14'h0040
            |=> status_words_q.word_a[rfsw_pkg::A_RUNT])
        else $error("short frame not flagged runt");

    a_runt_drop: assert property (
        frame_done && frame_info.short_frame && !ctrl_q[rfsw_pkg::CTL_KEEP_ERR]
            |=> status_valid_q && status_drop_q)
        else $error("runt kept without keep control");

    a_long_flag: assert property (
        frame_done && frame_info.byte_count > max_size_q && !ctrl_q[rfsw_pkg::CTL_FCS_STRIP]
            |=> status_words_q.word_a[rfsw_pkg::A_LONG]
                && status_words_q.word_a[13:0] == $past(frame_info.byte_count))
        else $error("long frame mishandled");

    a_phy_err_seen: assert property (
        rx_active && phy_rx_err && !frame_done ##1 !frame_done [*2] ##1 frame_done
            |=> status_words_q.word_a[rfsw_pkg::A_PHY_ERR]
                && status_words_q.word_a[rfsw_pkg::A_FCS])
        else $error("phy error lost before frame end");

    a_misalign_fcs: assert property (
        status_valid_q && status_words_q.word_a[rfsw_pkg::A_MISALIGN]
            |-> status_words_q.word_a[rfsw_pkg::A_FCS])
        else $error("misalign without check failure");

    a_len_strip: assert property (
        frame_done && ctrl_q[rfsw_pkg::CTL_FCS_STRIP] && frame_info.byte_count >= 14'h0004
            |=> status_words_q.word_a[13:0] == $past(frame_info.byte_count) - 14'h0004)
        else $error("stripped length wrong");

    a_fail_needs_wake: assert property (
        status_valid_q && status_words_q.word_c[rfsw_pkg::C_FILT_FAIL]
            |-> status_words_q.word_c[rfsw_pkg::C_WAKE])
        else $error("filter fail without wake");

    a_overflow_drop: assert property (
        frame_done && frame_info.overflow |=> status_drop_q && $stable(stored_cnt_q))
        else $error("overflow frame not dropped");

    a_reserved_zero: assert property (
        status_words_q.word_c[13:0] == 14'h0000)
        else $error("reserved bits not zero");

    a_oversize_flag: assert property (
        frame_done |=> status_words_q.word_a[rfsw_pkg::A_OVERSIZE] == $past(frame_info.wdt_cut))
        else $error("watchdog truncation flag wrong");

    a_fcs_on_phy: assert property (
        status_valid_q && status_words_q.word_a[rfsw_pkg::A_PHY_ERR]
            |-> status_words_q.word_a[rfsw_pkg::A_FCS])
        else $error("phy error without check flag");

    a_single_flag: assert property (
        frame_done |=> status_words_q.word_a[rfsw_pkg::A_SINGLE]
                       == !$past(frame_info.dest_addr[40]))
        else $error("unicast flag wrong");

    a_no_raw_l3_sum_flag: assert property (
        frame_done |=> status_words_q.word_a[rfsw_pkg::A_NO_RAW_L3_SUM] == $past(frame_info.no_l4_sum))
        else $error("checksum not computed flag wrong");

    a_raw_sum: assert property (
        frame_done |=> status_words_q.word_b[31:16] == $past(frame_info.raw_sum))
        else $error("raw layer-3 sum not copied");

    a_wake_gate: assert property (
        frame_done && !(ctrl_q[rfsw_pkg::CTL_DEEP_SUSP] && ctrl_q[rfsw_pkg::CTL_STORE_WAKE])
            |=> !status_words_q.word_c[rfsw_pkg::C_WAKE])
        else $error("wake flag outside stored suspend");

    a_proto_class: assert property (
        frame_done |=> status_words_q.word_a[rfsw_pkg::A_PROTO_LO +: 2]
                       == $past(frame_info.proto_class))
        else $error("protocol class not copied");

    a_wb_ack_once: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    c_wake_stored: cover property (frame_done && wake_flag && !drop);
    c_fail_wake: cover property (frame_done && filter_reject_flag);
    c_runt_kept: cover property (frame_done && runt && !drop);
    c_wb_read: cover property (wb_req && !wb_we_i ##1 wb_ack_o);

endmodule : rfsw_top

// ### sim/rfsw_host_model.sv
// host side model: counts delivered status words and applies the host discard policy
`timescale 1ns/10ps
module rfsw_host_model (
    input  wire logic                  clock,
    input  wire logic                  arst_n,
    input  wire rfsw_pkg::rfsw_words_t status_words_q,
    input  wire logic                  status_valid_q,
    input  wire logic                  status_drop_q,
    output logic [15:0]                seen_cnt,
    output logic [15:0]                kept_cnt
);
    logic bad;

    // filter fail discards
    // a transport error is ignored when the sum was never computed
    assign bad = status_words_q.word_c[14] | status_words_q.word_a[31]
               | (status_words_q.word_a[30] & ~status_words_q.word_a[14]);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            seen_cnt <= 16'h0000;
            kept_cnt <= 16'h0000;
        end else if (status_valid_q && !status_drop_q) begin
            seen_cnt <= seen_cnt + 16'h0001;
            kept_cnt <= kept_cnt + {15'h0000, ~bad};
        end
    end
endmodule : rfsw_host_model

// ### sim/rfsw_top_bench.sv
// self-checking bench for the receive status word generator
`timescale 1ns/10ps
module rfsw_top_bench;
    logic                  clock = 0, arst_n = 0, rx_active = 0, phy_rx_err = 0, frame_done = 0;
    rfsw_pkg::rfsw_frame_t frame_info = '0;
    rfsw_pkg::rfsw_words_t status_words_q;
    logic                  status_valid_q, status_drop_q, wb_ack_o, took = 0, acc = 0, ldrop;
    logic                  wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0]            wb_adr_i = 8'h00;
    logic [3:0]            wb_sel_i = 4'h0;
    logic [31:0]           wb_dat_i = 32'h0, wb_dat_o, rd, la, lb, lc, lm;
    logic [15:0]           seen_cnt, kept_cnt, n_kept = 0, n_drop = 0, n_host = 0;
    logic [5:0]            ctl = 6'h20;
    logic [13:0]           mx = 14'h05EE;
    int                    n_errors = 0, num_checks = 0, nf = 0;
    rfsw_pkg::rfsw_frame_t fq[$];
    logic                  pq[$];

    always #12.5 clock = ~clock;

    rfsw_top DUT (.clock(clock), .arst_n(arst_n), .rx_active(rx_active), .phy_rx_err(phy_rx_err),
        .frame_done(frame_done), .frame_info(frame_info), .status_words_q(status_words_q),
        .status_valid_q(status_valid_q), .status_drop_q(status_drop_q), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

    rfsw_host_model host (.clock(clock), .arst_n(arst_n), .status_words_q(status_words_q),
        .status_valid_q(status_valid_q), .status_drop_q(status_drop_q),
        .seen_cnt(seen_cnt), .kept_cnt(kept_cnt));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // classic cycle: hold everything until ack is sampled, then release for a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int k = 0;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge clock);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (k >= 20) chk("wb_ack_timeout", 32'h0, 32'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb

    function automatic logic rb();
        return ($urandom % 4) == 0;
    endfunction : rb

    function automatic rfsw_pkg::rfsw_frame_t rnd_frame(input int i);
        rfsw_pkg::rfsw_frame_t f;
        logic [13:0]           lens[10];
        lens = '{14'h0, 14'h3, 14'h4, 14'h3F, 14'h40, 14'h41, mx, mx + 14'h1, 14'h2C00,
                 14'($urandom % 1600)};
        f = '0;
        f.dest_addr = {16'($urandom), 32'($urandom)};
        if (i % 3 == 0) f.dest_addr = 48'hFFFF_FFFF_FFFF;
        else f.dest_addr[40] = (i % 3 == 1);
        f.byte_count = lens[$urandom % 10];
        {f.fcs_bad, f.misaligned, f.wdt_cut, f.short_frame} = {rb(), rb(), rb(), rb()};
        {f.ipv4_hdr_bad, f.l4_bad, f.no_l4_sum, f.tag_removed} = {rb(), rb(), rb(), rb()};
        f.proto_class = rfsw_pkg::rfsw_proto_t'(i % 4);
        f.tag = 16'($urandom);
        f.raw_sum = 16'($urandom);
        {f.wake_hit, f.filter_miss, f.overflow} = {1'($urandom), 1'($urandom), rb() & rb()};
        return f;
    endfunction : rnd_frame

    function automatic logic [31:0] exp_a(input rfsw_pkg::rfsw_frame_t f, input logic pe);
        logic        bc, gr, rn, lg, al, fc, er;
        logic [13:0] ln;
        bc = f.dest_addr == 48'hFFFF_FFFF_FFFF;
        gr = f.dest_addr[40] & !bc;
        rn = f.short_frame | (f.byte_count < 14'h0040);
        lg = f.byte_count > mx;
        al = f.misaligned & f.fcs_bad & ctl[5];
        fc = f.fcs_bad | pe;
        er = fc | al | pe | lg | rn | f.wdt_cut | f.ipv4_hdr_bad | f.l4_bad;
        ln = (ctl[1] && f.byte_count >= 14'h0004) ? f.byte_count - 14'h0004 : f.byte_count;
        return {f.ipv4_hdr_bad, f.l4_bad, 1'b0, f.proto_class, 1'b0, bc, gr, f.tag_removed,
                er, f.wdt_cut, rn, lg, pe, al, fc, !f.dest_addr[40], f.no_l4_sum, ln};
    endfunction : exp_a

    task automatic chk_frame(input rfsw_pkg::rfsw_frame_t f, input logic pe);
        logic rn, wk, ff;
        rn = f.short_frame | (f.byte_count < 14'h0040);
        wk = f.wake_hit & ctl[4] & ctl[2];
        ff = wk & f.filter_miss & ctl[3];
        // the tag field is undefined for untagged frames, so it is masked then
        lm = f.tag_removed ? 32'hFFFF_FFFF : 32'hFFFF_0000;
        la = exp_a(f, pe);
        lb = {f.raw_sum, f.tag} & lm;
        lc = {16'h0, wk, ff, 14'h0};
        ldrop = f.overflow | (rn & !ctl[0]);
        chk("status_valid", status_valid_q, 32'h1);
        chk("word_a", status_words_q.word_a, la);
        chk("word_b", status_words_q.word_b & lm, lb);
        chk("word_c", status_words_q.word_c, lc);
        chk("drop", status_drop_q, ldrop);
        if (ldrop) n_drop++;
        else n_kept++;
        if (!ldrop && !(ff | la[31] | (la[30] & ~la[14]))) n_host++;
    endtask : chk_frame

    // one clock of frame side stimulus; the frame taken at this edge is checked after it
    task automatic step(input logic fd, input rfsw_pkg::rfsw_frame_t f, input logic ra,
                        input logic pe);
        @(posedge clock);
        frame_done <= fd;
        frame_info <= f;
        rx_active  <= ra;
        phy_rx_err <= pe;
        acc = acc | (ra & pe);
        if (fd) begin
            fq.push_back(f);
            pq.push_back(acc);
            acc = 1'b0;
        end
        @(negedge clock);
        if (took) chk_frame(fq.pop_front(), pq.pop_front());
        else chk("valid_idle", status_valid_q, 32'h0);
        took = fd;
    endtask : step

    initial begin
        #(25 * 8000);
        n_errors++;
        end_of_test();
    end

    initial begin
        void'($urandom(87415));
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        wb(0, rfsw_pkg::OFS_CTRL, 4'hF, 32'h0);
        chk("ctrl_reset", rd, 32'h20);
        wb(0, rfsw_pkg::OFS_MAXSZ, 4'hF, 32'h0);
        chk("maxsz_reset", rd, 32'h5EE);
        wb(1, 8'h18, 4'hF, 32'hFFFF_FFFF);
        wb(0, 8'h18, 4'hF, 32'h0);
        chk("unmapped", rd, 32'h0);
        wb(0, rfsw_pkg::OFS_COUNT, 4'hF, 32'h0);
        chk("count_reset", rd, 32'h0);
        wb(1, rfsw_pkg::OFS_CTRL, 4'hE, 32'hFF);
        wb(0, rfsw_pkg::OFS_CTRL, 4'hF, 32'h0);
        chk("ctrl_lane_off", rd, 32'h20);
        $display("test registers done");
        for (int t = 0; t < 24; t++) begin
            ctl = 6'($urandom);
            mx = (t % 2) ? 14'h05EE : 14'(100 + $urandom % 200);
            wb(1, rfsw_pkg::OFS_CTRL, 4'h1, {26'h0, ctl});
            wb(1, rfsw_pkg::OFS_MAXSZ, 4'h3, {18'h0, mx});
            wb(0, rfsw_pkg::OFS_CTRL, 4'hF, 32'h0);
            chk("ctrl_rw", rd, {26'h0, ctl});
            for (int j = 0; j < 12; j++) begin
                if ($urandom % 3 != 0) begin
                    step(1'b1, rnd_frame(nf), rb() | rb(), rb());
                    nf++;
                end else begin
                    step(1'b0, '0, 1'($urandom), rb());
                end
            end
            step(1'b0, '0, 1'b0, 1'b0);
            if (t == 0) wb(1, rfsw_pkg::OFS_WORD_A, 4'hF, 32'h0);
            // the copies show the last frame taken, whether it was kept or dropped
            if (nf > 0) begin
                wb(0, rfsw_pkg::OFS_WORD_A, 4'hF, 32'h0);
                chk("reg_word_a", rd, la);
                wb(0, rfsw_pkg::OFS_WORD_B, 4'hF, 32'h0);
                chk("reg_word_b", rd & lm, lb);
                wb(0, rfsw_pkg::OFS_WORD_C, 4'hF, 32'h0);
                chk("reg_word_c", rd, lc);
            end
            wb(0, rfsw_pkg::OFS_COUNT, 4'hF, 32'h0);
            chk("count", rd, {n_drop, n_kept});
            chk("host_seen", {16'h0, seen_cnt}, {16'h0, n_kept});
            chk("host_kept", {16'h0, kept_cnt}, {16'h0, n_host});
            $display("test traffic %0d done", t);
        end
        end_of_test();
    end
endmodule : rfsw_top_bench
